// file: hw/posm_pkg.sv
// Package: register map, field layout and source codes of the pin output mux
package posm_pkg;
  // Register word indexes; the byte address is four times the index
  localparam logic [7:0] PIN6_CTRL_INDEX = 8'h16;
  localparam logic [7:0] PIN7_CTRL_INDEX = 8'h17;
  localparam logic [9:0] PIN6_CTRL_ADDR  = {PIN6_CTRL_INDEX, 2'b00};
  localparam logic [9:0] PIN7_CTRL_ADDR  = {PIN7_CTRL_INDEX, 2'b00};
  localparam logic [9:0] STATUS_ADDR     = 10'h064;
  localparam logic [9:0] PORT_EN_ADDR    = 10'h068;
  localparam logic [7:0] CTRL_RESET      = 8'h00;
  localparam logic [3:0] PORT_EN_RESET   = 4'h0;
  // Field positions
  localparam int SEL_HI = 7;
  localparam int SEL_LO = 5;
  localparam int SRC_HI = 4;
  localparam int SRC_LO = 2;
  localparam int VAL_BIT = 1;
  localparam int EN_BIT  = 0;
  // Source codes
  localparam logic [2:0] SRC_DEVICE = 3'h4;
  localparam logic [2:0] SRC_TX0    = 3'h6;
  // Selections
  localparam logic [2:0] SEL_LOCK   = 3'h4;
  localparam logic [2:0] SEL_PASS   = 3'h5;
  localparam logic [2:0] SEL_FV     = 3'h6;
  localparam logic [2:0] SEL_LV     = 3'h7;
  localparam logic [2:0] DEV_VAL    = 3'h0;
  localparam logic [2:0] DEV_LOCK   = 3'h1;
  localparam logic [2:0] DEV_PASS_A = 3'h2;
  localparam logic [2:0] DEV_PASS_B = 3'h3;
  localparam logic [2:0] DEV_SYNC   = 3'h4;
  localparam logic [2:0] TX_PASSAND = 3'h0;
  localparam logic [2:0] TX_PASSOR  = 3'h1;
  localparam logic [2:0] TX_FV      = 3'h2;
  localparam logic [2:0] TX_LV      = 3'h3;
  localparam logic [2:0] TX_SYNCED  = 3'h4;
  localparam logic [2:0] TX_IRQ     = 3'h5;
  // AHB codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;
endpackage

// file: hw/posm_sync2.sv
// Two-flop synchroniser for a vector of pin-level inputs
`timescale 1ns/1ps
`default_nettype none
module posm_sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  // Data
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1;

  initial begin
    if (WIDTH < 1) $error("posm_sync2: WIDTH must be positive");
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1  <= '0;
      syncOut <= '0;
    end else begin
      stage1  <= asyncIn;
      syncOut <= stage1;
    end
  end
endmodule // posm_sync2
`default_nettype wire

// file: hw/posm_pin_mux.sv
// Source and selection decode for one output pin
`timescale 1ns/1ps
`default_nettype none
module posm_pin_mux (
  // Control byte
  input  wire logic [7:0] ctrl,
  // Receive port signals, bit n is port n
  input  wire logic [3:0] rxRemote0,
  input  wire logic [3:0] rxRemote1,
  input  wire logic [3:0] rxRemote2,
  input  wire logic [3:0] rxRemote3,
  input  wire logic [3:0] rxLock,
  input  wire logic [3:0] rxPass,
  input  wire logic [3:0] rxFrameValid,
  input  wire logic [3:0] rxLineValid,
  // Aggregates
  input  wire logic       devLockOr,
  input  wire logic       devPassAnd,
  input  wire logic       cameraSyncSignal,
  input  wire logic       txPassAnd,
  input  wire logic       txPassOr,
  input  wire logic       txFrameValid,
  input  wire logic       txLineValid,
  input  wire logic       txSynced,
  input  wire logic       txIrq,
  // Result
  output logic            pinData,
  output logic            pinEnable
);
  logic [2:0] sel;
  logic [2:0] src;
  logic [1:0] port;

  assign sel       = ctrl[posm_pkg::SEL_HI:posm_pkg::SEL_LO];
  assign src       = ctrl[posm_pkg::SRC_HI:posm_pkg::SRC_LO];
  assign port      = src[1:0];
  assign pinEnable = ctrl[posm_pkg::EN_BIT];

  always_comb begin
    pinData = 1'b0;
    if (!src[2]) begin
      unique case (sel)
        3'h0:               pinData = rxRemote0[port];
        3'h1:               pinData = rxRemote1[port];
        3'h2:               pinData = rxRemote2[port];
        3'h3:               pinData = rxRemote3[port];
        posm_pkg::SEL_LOCK: pinData = rxLock[port];
        posm_pkg::SEL_PASS: pinData = rxPass[port];
        posm_pkg::SEL_FV:   pinData = rxFrameValid[port];
        posm_pkg::SEL_LV:   pinData = rxLineValid[port];
      endcase
    end else if (src == posm_pkg::SRC_DEVICE) begin
      unique case (sel)
        posm_pkg::DEV_VAL:    pinData = ctrl[posm_pkg::VAL_BIT];
        posm_pkg::DEV_LOCK:   pinData = devLockOr;
        posm_pkg::DEV_PASS_A: pinData = devPassAnd;
        posm_pkg::DEV_PASS_B: pinData = devPassAnd;
        posm_pkg::DEV_SYNC:   pinData = cameraSyncSignal;
        default:              pinData = 1'b0;
      endcase
    end else if (src == posm_pkg::SRC_TX0) begin
      unique case (sel)
        posm_pkg::TX_PASSAND: pinData = txPassAnd;
        posm_pkg::TX_PASSOR:  pinData = txPassOr;
        posm_pkg::TX_FV:      pinData = txFrameValid;
        posm_pkg::TX_LV:      pinData = txLineValid;
        posm_pkg::TX_SYNCED:  pinData = txSynced;
        posm_pkg::TX_IRQ:     pinData = txIrq;
        default:              pinData = 1'b0;
      endcase
    end
  end
endmodule // posm_pin_mux
`default_nettype wire

// file: hw/posm_top.sv
// Pin output source mux: AHB-Lite registers, two pin muxes, registered pins
//
// Contract
// - Source field bits 4:2 picks pin source
// - Receive source: select 0-3 forwards remote inputs
// - Receive source: 100 lock, 101 pass
// - Receive source: 110 frame-valid, 111 line-valid
// - Device source select 000 drives local value
// - Device: 001 lock OR, 010/011 pass AND
// - Device: 100 frame sync, rest reserved
// - Transmit source: 000 pass AND, 001 OR
// - Transmit source: 010 frame-, 011 line-valid
// - Transmit: 100 synced, 101 interrupt, 110/111 reserved
// - Bit 1 holds the local output value
// - Bit 0 enables the pin driver
// - Second control byte at 0x17, reset 0x00
// - First control byte at 0x16, reset 0x00
`timescale 1ns/1ps
`default_nettype none
module posm_top #(
  parameter int NUM_PORTS = 4
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Receive port status pins, bit n is port n
  input  wire logic [3:0]  rxRemote0,
  input  wire logic [3:0]  rxRemote1,
  input  wire logic [3:0]  rxRemote2,
  input  wire logic [3:0]  rxRemote3,
  input  wire logic [3:0]  rxLock,
  input  wire logic [3:0]  rxPass,
  input  wire logic [3:0]  rxFrameValid,
  input  wire logic [3:0]  rxLineValid,
  // Device and transmit status pins
  input  wire logic        cameraSyncSignal,
  input  wire logic        txFrameValid,
  input  wire logic        txLineValid,
  input  wire logic        txSynced,
  input  wire logic        txIrq,
  // Output pins
  output logic             pin6Out,
  output logic             pin6Oe,
  output logic             pin7Out,
  output logic             pin7Oe
);
  localparam int NS = 37;

  initial begin
    if (NUM_PORTS != 4) $error("posm_top: port codes serve exactly four ports");
  end

  // Every status input crosses in from other logic domains
  logic [NS-1:0] rawIn;
  logic [NS-1:0] syncIn;
  logic [3:0]    sRemote0;
  logic [3:0]    sRemote1;
  logic [3:0]    sRemote2;
  logic [3:0]    sRemote3;
  logic [3:0]    sLock;
  logic [3:0]    sPass;
  logic [3:0]    sFv;
  logic [3:0]    sLv;
  logic          sSync;
  logic          sTxFv;
  logic          sTxLv;
  logic          sTxSynced;
  logic          sTxIrq;

  assign rawIn = {rxRemote0, rxRemote1, rxRemote2, rxRemote3, rxLock, rxPass,
                  rxFrameValid, rxLineValid, cameraSyncSignal, txFrameValid,
                  txLineValid, txSynced, txIrq};
  assign {sRemote0, sRemote1, sRemote2, sRemote3, sLock, sPass, sFv, sLv,
          sSync, sTxFv, sTxLv, sTxSynced, sTxIrq} = syncIn;

  posm_sync2 #(.WIDTH(NS)) uSync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .asyncIn (rawIn),
    .syncOut (syncIn)
  );

  // Registers
  logic [7:0] pin6OutputControl;
  logic [7:0] pin7OutputControl;
  logic [3:0] portEnable;
  logic [3:0] portSelect;

  // AHB address phase capture
  logic       wrPending;
  logic       rdPending;
  logic [9:0] dataAddr;
  logic       addrPhase;

  assign addrPhase = hsel && hready && (htrans == posm_pkg::HTRANS_NONSEQ);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPending <= 1'b0;
      rdPending <= 1'b0;
      dataAddr  <= '0;
    end else if (hready) begin
      wrPending <= addrPhase && hwrite;
      rdPending <= addrPhase && !hwrite;
      dataAddr  <= haddr[9:0];
    end
  end

  // Zero wait states; every response is OKAY
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin6OutputControl <= posm_pkg::CTRL_RESET;
      pin7OutputControl <= posm_pkg::CTRL_RESET;
      portEnable        <= posm_pkg::PORT_EN_RESET;
      portSelect        <= posm_pkg::PORT_EN_RESET;
    end else if (wrPending) begin
      unique case (dataAddr)
        posm_pkg::PIN6_CTRL_ADDR: pin6OutputControl <= hwdata[7:0];
        posm_pkg::PIN7_CTRL_ADDR: pin7OutputControl <= hwdata[7:0];
        posm_pkg::PORT_EN_ADDR: begin
          portEnable <= hwdata[3:0];
          portSelect <= hwdata[11:8];
        end
        default: ;
      endcase
    end
  end

  // Read data: decoded in the address phase so hrdata is a flop
  logic [31:0] next_hrdata;
  logic        next_pin6Out;
  logic        next_pin7Out;
  logic        next_pin6Oe;
  logic        next_pin7Oe;

  always_comb begin
    next_hrdata = 32'h0000_0000;
    unique case (haddr[9:0])
      posm_pkg::PIN6_CTRL_ADDR: next_hrdata = {24'h000000, pin6OutputControl};
      posm_pkg::PIN7_CTRL_ADDR: next_hrdata = {24'h000000, pin7OutputControl};
      posm_pkg::PORT_EN_ADDR:   next_hrdata = {20'h00000, portSelect, 4'h0, portEnable};
      posm_pkg::STATUS_ADDR:    next_hrdata = {28'h0000000, pin7Oe, pin7Out, pin6Oe, pin6Out};
      default:                  next_hrdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (addrPhase && !hwrite) begin
      hrdata <= next_hrdata;
    end else if (!rdPending) begin
      hrdata <= 32'h0000_0000;
    end
  end

  // Aggregates over enabled or selected receive ports
  logic devLockOr;
  logic devPassAnd;
  logic txPassAnd;
  logic txPassOr;

  assign devLockOr  = |(sLock & portEnable);
  assign devPassAnd = &(sPass | ~portEnable);
  assign txPassAnd  = &(sPass | ~portSelect);
  assign txPassOr   = |(sPass & portSelect);

  posm_pin_mux uMux6 (
    .ctrl             (pin6OutputControl),
    .rxRemote0        (sRemote0),
    .rxRemote1        (sRemote1),
    .rxRemote2        (sRemote2),
    .rxRemote3        (sRemote3),
    .rxLock           (sLock),
    .rxPass           (sPass),
    .rxFrameValid     (sFv),
    .rxLineValid      (sLv),
    .devLockOr        (devLockOr),
    .devPassAnd       (devPassAnd),
    .cameraSyncSignal (sSync),
    .txPassAnd        (txPassAnd),
    .txPassOr         (txPassOr),
    .txFrameValid     (sTxFv),
    .txLineValid      (sTxLv),
    .txSynced         (sTxSynced),
    .txIrq            (sTxIrq),
    .pinData          (next_pin6Out),
    .pinEnable        (next_pin6Oe)
  );

  posm_pin_mux uMux7 (
    .ctrl             (pin7OutputControl),
    .rxRemote0        (sRemote0),
    .rxRemote1        (sRemote1),
    .rxRemote2        (sRemote2),
    .rxRemote3        (sRemote3),
    .rxLock           (sLock),
    .rxPass           (sPass),
    .rxFrameValid     (sFv),
    .rxLineValid      (sLv),
    .devLockOr        (devLockOr),
    .devPassAnd       (devPassAnd),
    .cameraSyncSignal (sSync),
    .txPassAnd        (txPassAnd),
    .txPassOr         (txPassOr),
    .txFrameValid     (sTxFv),
    .txLineValid      (sTxLv),
    .txSynced         (sTxSynced),
    .txIrq            (sTxIrq),
    .pinData          (next_pin7Out),
    .pinEnable        (next_pin7Oe)
  );

  // Data forced low while disabled so a released pin never carries stale data
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin6Out <= 1'b0;
      pin6Oe  <= 1'b0;
      pin7Out <= 1'b0;
      pin7Oe  <= 1'b0;
    end else begin
      pin6Oe  <= next_pin6Oe;
      pin7Oe  <= next_pin7Oe;
      pin6Out <= next_pin6Out & next_pin6Oe;
      pin7Out <= next_pin7Out & next_pin7Oe;
    end
  end

  // Checks
  sequence wrPin6_s;
    wrPending && dataAddr == posm_pkg::PIN6_CTRL_ADDR;
  endsequence

  pin6_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wrPin6_s |=> pin6OutputControl == $past(hwdata[7:0]))
    else $error("pin6 control byte not written");
  pin7_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wrPending && dataAddr == posm_pkg::PIN7_CTRL_ADDR |=> pin7OutputControl == $past(hwdata[7:0]))
    else $error("pin7 control byte not written");
  oe_follow_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ##1 pin6Oe == $past(pin6OutputControl[posm_pkg::EN_BIT]))
    else $error("pin6 enable does not follow bit 0");
  off_low_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !pin7Oe |-> !pin7Out)
    else $error("pin7 data high while disabled");
  local_val_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pin6OutputControl[7:2] == {posm_pkg::DEV_VAL, posm_pkg::SRC_DEVICE}
      && pin6OutputControl[posm_pkg::EN_BIT] |=> pin6Out == $past(pin6OutputControl[1]))
    else $error("local value not driven");
  lock_or_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pin6OutputControl == {posm_pkg::DEV_LOCK, posm_pkg::SRC_DEVICE, 2'b01}
      |=> pin6Out == $past(|(sLock & portEnable)))
    else $error("lock OR wrong");
  rx_fwd_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pin6OutputControl == 8'h05 |=> pin6Out == $past(sRemote0[1]))
    else $error("remote input 0 of port 1 not forwarded");
  rsvd_low_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pin7OutputControl[4:2] == 3'h5 || pin7OutputControl[4:2] == 3'h7 |=> !pin7Out)
    else $error("reserved source not low");
  tx_irq_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pin7OutputControl == {posm_pkg::TX_IRQ, posm_pkg::SRC_TX0, 2'b01}
      |=> pin7Out == $past(sTxIrq))
    else $error("transmit interrupt not driven");

  // Read data is the byte as it stood at the address phase
  sequence rdPin7_s;
    addrPhase && !hwrite && haddr[9:0] == posm_pkg::PIN7_CTRL_ADDR;
  endsequence

  // Held for three edges so a pin change has crossed both sync flops
  sequence fwdHeld_s;
    (pin6OutputControl == 8'h05) [*3];
  endsequence

  sequence dev7Pass_s;
    pin7OutputControl[posm_pkg::SRC_HI:posm_pkg::SRC_LO] == posm_pkg::SRC_DEVICE
      && (pin7OutputControl[posm_pkg::SEL_HI:posm_pkg::SEL_LO] == posm_pkg::DEV_PASS_A
        || pin7OutputControl[posm_pkg::SEL_HI:posm_pkg::SEL_LO] == posm_pkg::DEV_PASS_B)
      && pin7OutputControl[posm_pkg::EN_BIT];
  endsequence

  rd_data_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rdPin7_s |=> hrdata == {24'h000000, $past(pin7OutputControl)})
    else $error("pin7 control byte read back wrong");
  wr_to_oe_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wrPin6_s |-> ##2 pin6Oe == $past(hwdata[posm_pkg::EN_BIT], 2))
    else $error("pin6 enable does not follow the written byte");
  sync_fwd_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    fwdHeld_s |=> pin6Out == $past(rxRemote0[1], 3))
    else $error("remote input not on pin three edges later");
  en_off_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !pin6OutputControl[posm_pkg::EN_BIT] |=> !pin6Oe && !pin6Out)
    else $error("pin6 driven while enable bit clear");
  pass_and_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    dev7Pass_s |=> pin7Out == $past(&(sPass | ~portEnable)))
    else $error("device pass AND wrong");
  dev_sync_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pin6OutputControl == {posm_pkg::DEV_SYNC, posm_pkg::SRC_DEVICE, 2'b01}
      |=> pin6Out == $past(sSync))
    else $error("frame sync not driven");
  dev_rsvd_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pin7OutputControl[posm_pkg::SRC_HI:posm_pkg::SRC_LO] == posm_pkg::SRC_DEVICE
      && pin7OutputControl[posm_pkg::SEL_HI:posm_pkg::SEL_LO] > posm_pkg::DEV_SYNC
      |=> !pin7Out)
    else $error("reserved device selection not low");
  rx_lock_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !pin7OutputControl[posm_pkg::SRC_HI]
      && pin7OutputControl[posm_pkg::SEL_HI:posm_pkg::SEL_LO] == posm_pkg::SEL_LOCK
      |=> pin7Out == $past(sLock[pin7OutputControl[3:2]] & pin7OutputControl[0]))
    else $error("receive port lock not driven");
  rx_fv_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !pin6OutputControl[posm_pkg::SRC_HI]
      && pin6OutputControl[posm_pkg::SEL_HI:posm_pkg::SEL_LO] == posm_pkg::SEL_FV
      |=> pin6Out == $past(sFv[pin6OutputControl[3:2]] & pin6OutputControl[0]))
    else $error("receive port frame-valid not driven");
  tx_pass_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pin7OutputControl == {posm_pkg::TX_PASSOR, posm_pkg::SRC_TX0, 2'b01}
      |=> pin7Out == $past(|(sPass & portSelect)))
    else $error("transmit pass OR wrong");
  tx_fv_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pin6OutputControl == {posm_pkg::TX_FV, posm_pkg::SRC_TX0, 2'b01}
      |=> pin6Out == $past(sTxFv))
    else $error("transmit frame-valid not driven");
  rsvd_src_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pin6OutputControl[posm_pkg::SRC_HI:posm_pkg::SRC_LO] == 3'h5 |=> !pin6Out)
    else $error("reserved source not low on pin6");
endmodule // posm_top
`default_nettype wire

// file: verification/posm_pin_sampler.sv
// Far-side model: logic that samples one general-purpose output pin
`timescale 1ns/1ps
`default_nettype none
module posm_pin_sampler (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // Pin as driven by the device
  input  wire logic pinOut,
  input  wire logic pinOe,
  // Level seen on the wire
  output logic      pinLevel
);
  logic lastLevel;

  // No pull on the line: a released pin must not look like its last value
  assign pinLevel = pinOe ? pinOut : ~lastLevel;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lastLevel <= 1'b0;
    end else if (pinOe) begin
      lastLevel <= pinOut;
    end
  end
endmodule // posm_pin_sampler
`default_nettype wire

// file: verification/pin_output_source_mux_tb_top.sv
// Self-checking bench for the pin output source mux
`timescale 1ns/1ps
`default_nettype none
module pin_output_source_mux_tb_top;
  localparam logic [31:0] A6  = {22'h0, posm_pkg::PIN6_CTRL_ADDR};
  localparam logic [31:0] A7  = {22'h0, posm_pkg::PIN7_CTRL_ADDR};
  localparam logic [31:0] AST = {22'h0, posm_pkg::STATUS_ADDR};
  localparam logic [31:0] AEN = {22'h0, posm_pkg::PORT_EN_ADDR};
  logic        ref_clk;
  logic        rst_n;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [3:0]  rxv [8];
  logic [4:0]  misc;
  logic        pin6Out, pin6Oe, pin7Out, pin7Oe, lvl6, lvl7;
  int          errCount = 0;
  int          totalChecks = 0;
  int          cycles = 0;

  posm_top uut (.ref_clk(ref_clk), .rst_n(rst_n), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .rxRemote0(rxv[0]), .rxRemote1(rxv[1]), .rxRemote2(rxv[2]), .rxRemote3(rxv[3]),
    .rxLock(rxv[4]), .rxPass(rxv[5]), .rxFrameValid(rxv[6]), .rxLineValid(rxv[7]),
    .cameraSyncSignal(misc[0]), .txFrameValid(misc[1]), .txLineValid(misc[2]),
    .txSynced(misc[3]), .txIrq(misc[4]), .pin6Out(pin6Out), .pin6Oe(pin6Oe),
    .pin7Out(pin7Out), .pin7Oe(pin7Oe));
  posm_pin_sampler p6 (.ref_clk(ref_clk), .rst_n(rst_n), .pinOut(pin6Out),
    .pinOe(pin6Oe), .pinLevel(lvl6));
  posm_pin_sampler p7 (.ref_clk(ref_clk), .rst_n(rst_n), .pinOut(pin7Out),
    .pinOe(pin7Oe), .pinLevel(lvl7));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", totalChecks, errCount);
    if (errCount == 0 && totalChecks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Whole run needs about 1200 cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errCount++;
      conclude();
    end
  end

  task automatic chk_bit(input logic g, input logic e);
    totalChecks++;
    if (g !== e) begin
      errCount++;
      $display("MISMATCH %0t pin bit got %b expected %b", $time, g, e);
    end
  endtask

  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    totalChecks++;
    if (g !== e) begin
      errCount++;
      $display("MISMATCH %0t read got %h expected %h", $time, g, e);
    end
  endtask

  task automatic ahb_cycle(input logic [31:0] a, input logic w, input logic [31:0] d,
                           output logic [31:0] rd);
    @(posedge ref_clk);
    htrans <= posm_pkg::HTRANS_NONSEQ;
    haddr  <= a;
    hwrite <= w;
    hsize  <= posm_pkg::HSIZE_WORD;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic ahb_write(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] rd;
    ahb_cycle(a, 1'b1, d, rd);
  endtask

  task automatic ahb_read(input logic [31:0] a, output logic [31:0] rd);
    ahb_cycle(a, 1'b0, 32'h0, rd);
  endtask

  // Program one pin, read it back, then judge the pin after sync latency
  task automatic try(input int p, input logic [7:0] c, input logic e);
    logic [31:0] rd;
    ahb_write(p ? A7 : A6, {24'h0, c});
    ahb_read(p ? A7 : A6, rd);
    chk_word(rd, {24'h0, c});
    repeat (4) @(posedge ref_clk);
    #1;
    chk_bit(p ? pin7Oe : pin6Oe, c[0]);
    chk_bit(p ? pin7Out : pin6Out, e & c[0]);
    if (c[0]) chk_bit(p ? lvl7 : lvl6, e);
  endtask

  task automatic t_reset();
    logic [31:0] rd;
    ahb_read(A6, rd);
    chk_word(rd, 32'h0);
    ahb_read(A7, rd);
    chk_word(rd, 32'h0);
    chk_bit(pin6Oe | pin7Oe, 1'b0);
    ahb_write(32'h100, 32'hff);
    ahb_read(32'h100, rd);
    chk_word(rd, 32'h0);
    ahb_read(A6, rd);
    chk_word(rd, 32'h0);
    chk_bit(hresp, 1'b0);
  endtask

  task automatic t_rx();
    logic [3:0] pat [8];
    pat = '{4'h5, 4'ha, 4'h3, 4'hc, 4'h6, 4'h9, 4'h1, 4'he};
    for (int ph = 0; ph < 2; ph++) begin
      @(posedge ref_clk);
      for (int k = 0; k < 8; k++) rxv[k] <= ph ? ~pat[k] : pat[k];
      for (int s = 0; s < 4; s++) begin
        for (int q = 0; q < 8; q++) begin
          try((s + ph) % 2, {q[2:0], s[2:0], 2'b01}, pat[q][s] ^ ph[0]);
        end
      end
    end
  endtask

  task automatic t_dev();
    logic [31:0] rd;
    ahb_write(AEN, 32'h305);
    @(posedge ref_clk);
    rxv[4] <= 4'b1010;
    rxv[5] <= 4'b0101;
    misc   <= 5'h1e;
    try(0, 8'h13, 1'b1);
    try(0, 8'h11, 1'b0);
    try(1, 8'h31, 1'b0);
    try(1, 8'h51, 1'b1);
    try(1, 8'h71, 1'b1);
    try(0, 8'h91, 1'b0);
    @(posedge ref_clk);
    rxv[4] <= 4'b0100;
    rxv[5] <= 4'b0001;
    misc   <= 5'h01;
    try(0, 8'h31, 1'b1);
    try(1, 8'h51, 1'b0);
    try(1, 8'h71, 1'b0);
    try(0, 8'h91, 1'b1);
    ahb_read(AST, rd);
    chk_word(rd, 32'h0000000b);
    ahb_read(AEN, rd);
    chk_word(rd, 32'h00000305);
  endtask

  task automatic t_tx();
    @(posedge ref_clk);
    rxv[5] <= 4'b0001;
    misc   <= 5'h00;
    try(0, 8'h19, 1'b0);
    try(1, 8'h39, 1'b1);
    @(posedge ref_clk);
    rxv[5] <= 4'b1100;
    try(1, 8'h39, 1'b0);
    @(posedge ref_clk);
    rxv[5] <= 4'b0011;
    try(0, 8'h19, 1'b1);
    for (int q = 2; q < 6; q++) begin
      @(posedge ref_clk);
      misc <= 5'h01 << (q - 1);
      try(q % 2, {q[2:0], 3'h6, 2'b01}, 1'b1);
      @(posedge ref_clk);
      misc <= ~(5'h01 << (q - 1));
      try(q % 2, {q[2:0], 3'h6, 2'b01}, 1'b0);
    end
  endtask

  task automatic t_res();
    @(posedge ref_clk);
    for (int k = 0; k < 8; k++) rxv[k] <= 4'hf;
    misc <= 5'h1f;
    for (int q = 5; q < 8; q++) try(q % 2, {q[2:0], 3'h4, 2'b11}, 1'b0);
    for (int q = 0; q < 8; q++) begin
      try(0, {q[2:0], 3'h5, 2'b11}, 1'b0);
      try(1, {q[2:0], 3'h7, 2'b11}, 1'b0);
    end
    try(0, 8'hd9, 1'b0);
    try(1, 8'hf9, 1'b0);
    try(0, 8'h12, 1'b1);
    try(1, 8'he0, 1'b1);
  endtask

  // Mid-run reset must clear both control bytes and release the pins
  task automatic t_rst2();
    logic [31:0] rd;
    try(0, 8'h13, 1'b1);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    chk_bit(pin6Oe | pin6Out | pin7Oe | pin7Out, 1'b0);
    @(posedge ref_clk);
    rst_n <= 1'b1;
    ahb_read(A6, rd);
    chk_word(rd, 32'h0);
    ahb_read(A7, rd);
    chk_word(rd, 32'h0);
    repeat (2) @(posedge ref_clk);
    #1;
    chk_bit(pin6Oe | pin7Oe, 1'b0);
  endtask

  initial begin
    rst_n  = 1'b0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h0;
    hwdata = 32'h0;
    misc   = 5'h00;
    for (int k = 0; k < 8; k++) rxv[k] = 4'h0;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset();
    t_rx();
    t_dev();
    t_tx();
    t_res();
    t_rst2();
    conclude();
  end
endmodule // pin_output_source_mux_tb_top
`default_nettype wire
